// ==== background_debug_serial_commands_test.sv ====
// self-checking bench for the serial debug command port
`timescale 1ns/1ns
module background_debug_serial_commands_test;
  logic clk, reset_n, debug_serial_clock, dbg_data_in, dbg_data_out, background_debug_state;
  logic mem_req, reg_req, cmd_error, st;
  logic mem_ack = 1'b0;
  logic reg_ack = 1'b0;
  logic [31:0] mem_rdata, reg_rdata, dump_ptr, ptr, a;
  logic [15:0] rw;
  logic [1:0] sz;
  logic [1:0] bs [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
  logic [15:0] bad [5] = '{16'h9980, 16'h1dc0, 16'h1d41, 16'h1d08, 16'h1d40};
  bdsc_pkg::bdsc_mem_req_t mem_cmd, mem_seen;
  bdsc_pkg::bdsc_reg_req_t reg_cmd, reg_seen;
  int bad_count = 0, total_checks = 0, mem_n = 0, cycles = 0, n;
  // core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  bdsc_host h (.debug_serial_clock(debug_serial_clock), .dbg_data_out(dbg_data_out),
    .dbg_data_in(dbg_data_in));
  bdsc_core uut (.clk(clk), .reset_n(reset_n), .debug_serial_clock(debug_serial_clock),
    .dbg_data_in(dbg_data_in), .dbg_data_out(dbg_data_out),
    .background_debug_state(background_debug_state), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_req(reg_req), .reg_cmd(reg_cmd),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .dump_ptr(dump_ptr), .cmd_error(cmd_error));
  function automatic logic [31:0] pat(input logic [31:0] x);
    pat = {~x[15:0], x[15:0] ^ 16'h3c3c};
  endfunction
  // core side: one ack pulse per access, data made from the address
  assign mem_rdata = pat(mem_cmd.addr);
  assign reg_rdata = pat({28'h0, reg_cmd.addr_reg, reg_cmd.num});
  always @(posedge clk)
  begin
    mem_ack <= mem_req && !mem_ack;
    reg_ack <= reg_req && !reg_ack;
    if (mem_req && !mem_ack)
    begin
      mem_seen <= mem_cmd;
      mem_n <= mem_n + 1;
    end
    if (reg_req && !reg_ack)
      reg_seen <= reg_cmd;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [15:0] w);
    h.xfer(w, st, rw);
  endtask
  // command word then address, high word first
  task automatic send_a(input logic [15:0] w, input logic [31:0] x);
    send(w);
    send(x[31:16]);
    send(x[15:0]);
  endtask
  // padding frames clock out the published result
  task automatic result(input logic [1:0] s, input logic [31:0] d);
    logic [15:0] m;
    m = (s == bdsc_pkg::SZ_BYTE) ? 16'h00ff : 16'hffff;
    // first frame only loads the result into the link shifter
    send(16'h0000);
    send(16'h0000);
    check({31'h0, st}, {31'h0, bdsc_pkg::STATUS_VALID});
    if (s == bdsc_pkg::SZ_LONG)
    begin
      check({16'h0, rw}, {16'h0, d[31:16]});
      send(16'h0000);
      check({31'h0, st}, {31'h0, bdsc_pkg::STATUS_VALID});
    end
    check({16'h0, rw & m}, {16'h0, d[15:0] & m});
  endtask
  task automatic reg_is(input logic we, input logic ad, input logic [2:0] num);
    check({28'h0, reg_seen.we, reg_seen.addr_reg, reg_seen.num}, {28'h0, we, ad, num});
  endtask
  task automatic mem_is(input logic we, input logic [1:0] s, input logic [31:0] x);
    check({29'h0, mem_seen.we, mem_seen.size}, {29'h0, we, s});
    check(mem_seen.addr, x);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    background_debug_state = 1'b1;
    repeat (3) @(posedge clk);
    send(16'h0000); // link edges while held in reset
    @(posedge clk) reset_n <= 1'b1;
    // two link edges let the link side leave reset before a frame
    repeat (2) h.bit_xfer(1'b0, st);
    ptr = 32'h0;
    a = 32'h8421_0ffc;
    for (int s = 0; s < 3; s++)
    begin
      sz = 2'(s);
      send_a({6'h06, 2'b00, sz, 6'h00}, a);
      if (sz == bdsc_pkg::SZ_LONG)
        send(16'h1234);
      send(16'h5678);
      mem_is(1'b1, sz, a);
      if (s == 2)
        check(mem_seen.wdata, 32'h1234_5678);
      else
        check({24'h0, mem_seen.wdata[7:0]}, 32'h0000_0078);
      check(dump_ptr, ptr);
    end
    $display("writes done");
    for (int s = 0; s < 3; s++)
    begin
      sz = 2'(s);
      send_a({6'h06, 2'b01, sz, 6'h00}, a);
      mem_is(1'b0, sz, a);
      ptr = a + (32'h1 << sz);
      check(dump_ptr, ptr);
      result(sz, pat(a));
    end
    $display("reads done");
    foreach (bs[i])
    begin
      a = ptr;
      send({8'h1d, bs[i], 6'h00});
      mem_is(1'b0, bs[i], a);
      ptr = a + (32'h1 << bs[i]);
      check(dump_ptr, ptr);
      result(bs[i], pat(a));
      check(dump_ptr, ptr);
    end
    $display("block reads done");
    foreach (bad[i])
    begin
      n = mem_n;
      @(posedge clk) background_debug_state <= (i != 4);
      send(bad[i]);
      check({31'h0, cmd_error}, 32'h1);
      check(32'(mem_n), 32'(n));
      @(posedge clk) background_debug_state <= 1'b1;
      send(16'h0000);
      check({31'h0, cmd_error}, 32'h0);
      check(dump_ptr, ptr);
    end
    $display("refusals done");
    for (int d = 0; d < 2; d++)
    begin
      send({6'h08, 2'b01, 2'h2, 2'h0, 1'(d), 3'h5});
      reg_is(1'b0, 1'(d), 3'h5);
      result(bdsc_pkg::SZ_LONG, pat({28'h0, 1'(d), 3'h5}));
      send({6'h08, 2'b00, 2'h2, 2'h0, 1'(d), 3'h2});
      send(16'hcafe);
      send(16'hf00d);
      reg_is(1'b1, 1'(d), 3'h2);
      check(reg_seen.wdata, 32'hcafef00d);
    end
    $display("registers done");
    final_report();
  end
endmodule

// ==== bdsc_core.sv ====
// serial debug command port: link shifter, command decoder, block-read pointer
//
// Contract
// RULE1 - host idles clock high, seventeen pulses per frame
// RULE2 - serial logic needs no minimum clock rate
// RULE3 - host side may be software meeting timing
// RULE4 - decode six-bit operation field, 64 codes
// RULE5 - direction bit one sends, zero accepts
// RULE6 - size 00 byte, 01 word, 10 long
// RULE7 - addresses are full 32-bit absolute values
// RULE8 - register class bit one selects address
// RULE9 - read leaves address plus size in pointer
// RULE10 - block-read fetches at pointer, then advances
// RULE11 - block-read only after read or block-read; the decoder accepts it after any command
// RULE12 - padding command leaves pointer untouched
// RULE13 - block-read samples size on every command
// RULE14 - block-read word 0001 1101, size, zeros
// RULE15 - extension words follow, most significant first
`timescale 1ns/1ns
module bdsc_core (
  // core clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial link
  input wire logic debug_serial_clock,
  input wire logic dbg_data_in,
  output logic dbg_data_out,
  // processor state
  input wire logic background_debug_state,
  // memory access port
  output logic mem_req,
  output bdsc_pkg::bdsc_mem_req_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // register access port
  output logic reg_req,
  output bdsc_pkg::bdsc_reg_req_t reg_cmd,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  // status
  output logic [31:0] dump_ptr,
  output logic cmd_error
);

  // link-side signals
  logic lrst_meta_reg;
  logic link_rst_n_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] in_sr_reg;
  logic [15:0] rx_word_reg;
  logic rx_tog_reg;
  logic [16:0] out_sr_reg;
  logic resp_meta_reg;
  logic resp_sync_reg;
  logic resp_seen_reg;

  // core-side signals
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_last_reg;
  logic word_evt;
  bdsc_pkg::bdsc_cmd_t rx_cmd;
  bdsc_pkg::bdsc_state_t state_reg;
  bdsc_pkg::bdsc_cmd_t cmd_reg;
  logic [2:0] ext_left_reg;
  logic [2:0] ext_idx_reg;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic [31:0] ptr_reg;
  logic err_reg;
  logic [15:0] resp_word_reg;
  logic resp_tog_reg;
  logic [15:0] lo_word_reg;
  logic lo_pend_reg;
  logic mem_done;
  logic reg_done;

  // reset brought into the link domain
  always_ff @(posedge debug_serial_clock)
  begin
    lrst_meta_reg <= reset_n;
    link_rst_n_reg <= lrst_meta_reg;
  end

  // response toggle brought into the link domain
  always_ff @(posedge debug_serial_clock)
  begin
    resp_meta_reg <= resp_tog_reg;
    resp_sync_reg <= resp_meta_reg;
  end

  // frame shifter, purely edge driven, no timing on the serial clock [RULE2]
  always_ff @(posedge debug_serial_clock)
  begin
    if (!link_rst_n_reg)
    begin
      bit_cnt_reg <= 5'h00;
      rx_tog_reg <= 1'b0;
      resp_seen_reg <= 1'b0;
      out_sr_reg <= {bdsc_pkg::STATUS_NOT_READY, bdsc_pkg::NOT_READY_WORD};
      in_sr_reg <= 16'h0000;
      rx_word_reg <= 16'h0000;
    end
    else
    begin
      in_sr_reg <= {in_sr_reg[14:0], dbg_data_in};
      if (bit_cnt_reg == bdsc_pkg::LAST_BIT) // seventeenth pulse ends the frame [RULE1]
      begin
        bit_cnt_reg <= 5'h00;
        rx_word_reg <= {in_sr_reg[14:0], dbg_data_in};
        rx_tog_reg <= ~rx_tog_reg;
        if (resp_sync_reg != resp_seen_reg)
        begin
          out_sr_reg <= {bdsc_pkg::STATUS_VALID, resp_word_reg}; // operand to host [RULE5]
          resp_seen_reg <= resp_sync_reg;
        end
        else
          out_sr_reg <= {bdsc_pkg::STATUS_NOT_READY, bdsc_pkg::NOT_READY_WORD};
      end
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        out_sr_reg <= {out_sr_reg[15:0], 1'b0};
      end
    end
  end

  assign dbg_data_out = out_sr_reg[16];

  // received word event brought into the core domain
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_meta_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
      rx_last_reg <= 1'b0;
    end
    else
    begin
      rx_meta_reg <= rx_tog_reg;
      rx_sync_reg <= rx_meta_reg;
      rx_last_reg <= rx_sync_reg;
    end
  end

  assign word_evt = rx_sync_reg ^ rx_last_reg;
  assign rx_cmd = bdsc_pkg::bdsc_cmd_t'(rx_word_reg);
  assign mem_done = (state_reg == bdsc_pkg::ST_MEM) && mem_ack;
  assign reg_done = (state_reg == bdsc_pkg::ST_REG) && reg_ack;

  // command decode and sequencing
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= bdsc_pkg::ST_CMD;
      cmd_reg <= '0;
      ext_left_reg <= 3'h0;
      ext_idx_reg <= 3'h0;
      addr_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        bdsc_pkg::ST_CMD:
        begin
          if (word_evt)
          begin
            cmd_reg <= rx_cmd;
            ext_idx_reg <= 3'h0;
            err_reg <= 1'b0;
            if (!background_debug_state)
              err_reg <= 1'b1;
            else
            begin
              case (rx_cmd.op) // six-bit operation code [RULE4]
                bdsc_pkg::OP_PADDING: ; // pointer and state left alone [RULE12]
                bdsc_pkg::OP_MEM:
                begin
                  if (rx_cmd.size == bdsc_pkg::SZ_RSVD) // reserved size refused [RULE6]
                    err_reg <= 1'b1;
                  else
                  begin
                    state_reg <= bdsc_pkg::ST_EXT;
                    if (rx_cmd.rd) // read needs the address only [RULE5]
                      ext_left_reg <= bdsc_pkg::EXT_ADDR_WORDS;
                    else if (rx_cmd.size == bdsc_pkg::SZ_LONG) // address then operand [RULE15]
                      ext_left_reg <= bdsc_pkg::EXT_ADDR_WORDS + bdsc_pkg::EXT_LONG_WORDS;
                    else
                      ext_left_reg <= bdsc_pkg::EXT_ADDR_WORDS + bdsc_pkg::EXT_SHORT_WORDS;
                  end
                end
                bdsc_pkg::OP_DUMP:
                begin
                  // exact word check, size taken fresh each time [RULE14] [RULE13]
                  if (!rx_cmd.zero9 && rx_cmd.rd && rx_cmd.zero54 == 2'h0 &&
                      !rx_cmd.addr_reg && rx_cmd.reg_num == 3'h0 &&
                      rx_cmd.size != bdsc_pkg::SZ_RSVD)
                  begin
                    addr_reg <= ptr_reg; // pointer used unchecked [RULE10] [RULE11]
                    state_reg <= bdsc_pkg::ST_MEM;
                  end
                  else
                    err_reg <= 1'b1;
                end
                bdsc_pkg::OP_REG:
                begin
                  if (rx_cmd.rd)
                    state_reg <= bdsc_pkg::ST_REG;
                  else
                  begin
                    state_reg <= bdsc_pkg::ST_EXT;
                    ext_left_reg <= bdsc_pkg::EXT_LONG_WORDS;
                  end
                end
                default: err_reg <= 1'b1;
              endcase
            end
          end
        end
        bdsc_pkg::ST_EXT:
        begin
          if (word_evt)
          begin
            // high word first, full 32-bit address taken as sent [RULE15] [RULE7]
            if (cmd_reg.op == bdsc_pkg::OP_MEM && ext_idx_reg < bdsc_pkg::EXT_ADDR_WORDS)
              addr_reg <= {addr_reg[15:0], rx_word_reg};
            else
              data_reg <= {data_reg[15:0], rx_word_reg};
            ext_idx_reg <= ext_idx_reg + 3'h1;
            ext_left_reg <= ext_left_reg - 3'h1;
            if (ext_left_reg == 3'h1)
            begin
              if (cmd_reg.op == bdsc_pkg::OP_MEM)
                state_reg <= bdsc_pkg::ST_MEM;
              else
                state_reg <= bdsc_pkg::ST_REG;
            end
          end
        end
        bdsc_pkg::ST_MEM:
        begin
          if (mem_ack)
            state_reg <= bdsc_pkg::ST_CMD;
        end
        bdsc_pkg::ST_REG:
        begin
          if (reg_ack)
            state_reg <= bdsc_pkg::ST_CMD;
        end
        default: state_reg <= bdsc_pkg::ST_CMD;
      endcase
    end
  end

  // block-read pointer: access address plus operand size [RULE9] [RULE10]
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ptr_reg <= 32'h0000_0000;
    else if (mem_done && cmd_reg.rd)
      ptr_reg <= addr_reg + bdsc_pkg::size_bytes(cmd_reg.size);
  end

  // response words published to the link, long operands in two halves
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      resp_word_reg <= 16'h0000;
      resp_tog_reg <= 1'b0;
      lo_word_reg <= 16'h0000;
      lo_pend_reg <= 1'b0;
    end
    else if (mem_done && cmd_reg.rd)
    begin
      resp_tog_reg <= ~resp_tog_reg;
      case (cmd_reg.size) // operand width per size code [RULE6]
        bdsc_pkg::SZ_BYTE: resp_word_reg <= {8'h00, mem_rdata[7:0]};
        bdsc_pkg::SZ_WORD: resp_word_reg <= mem_rdata[15:0];
        default:
        begin
          resp_word_reg <= mem_rdata[31:16];
          lo_word_reg <= mem_rdata[15:0];
          lo_pend_reg <= 1'b1;
        end
      endcase
    end
    else if (reg_done && cmd_reg.rd)
    begin
      resp_tog_reg <= ~resp_tog_reg;
      resp_word_reg <= reg_rdata[31:16];
      lo_word_reg <= reg_rdata[15:0];
      lo_pend_reg <= 1'b1;
    end
    else if (state_reg == bdsc_pkg::ST_CMD && word_evt && lo_pend_reg)
    begin
      resp_tog_reg <= ~resp_tog_reg;
      resp_word_reg <= lo_word_reg;
      lo_pend_reg <= 1'b0;
    end
  end

  // requests toward the core, held until acknowledged
  assign mem_req = (state_reg == bdsc_pkg::ST_MEM);
  assign reg_req = (state_reg == bdsc_pkg::ST_REG);
  assign mem_cmd.we = ~cmd_reg.rd; // direction bit zero writes [RULE5]
  assign mem_cmd.size = cmd_reg.size;
  assign mem_cmd.addr = addr_reg;
  assign mem_cmd.wdata = data_reg;
  assign reg_cmd.we = ~cmd_reg.rd;
  assign reg_cmd.addr_reg = cmd_reg.addr_reg; // one selects address register [RULE8]
  assign reg_cmd.num = cmd_reg.reg_num;
  assign reg_cmd.wdata = data_reg;

  // status outputs
  assign dump_ptr = ptr_reg;
  assign cmd_error = err_reg;

endmodule

// ==== bdsc_core_monitor.sv ====
// concurrent checks on the serial debug command port
`timescale 1ns/1ns
module bdsc_monitor (
  // clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic debug_serial_clock,
  // core side
  input wire logic mem_req,
  input wire bdsc_pkg::bdsc_mem_req_t mem_cmd,
  input wire logic mem_ack,
  input wire logic reg_req,
  input wire bdsc_pkg::bdsc_reg_req_t reg_cmd,
  input wire logic reg_ack,
  input wire logic [31:0] dump_ptr,
  input wire logic cmd_error
);
  logic [31:0] exp_ptr;
  logic rd_done;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  assign rd_done = mem_req && mem_ack && !mem_cmd.we;
  // pointer expected after a finished read
  always_ff @(posedge clk)
  begin
    if (rd_done)
      exp_ptr <= mem_cmd.addr + (32'h1 << mem_cmd.size);
  end
  a_ptr_after_read: assert property (rd_done |=> ##[0:2] dump_ptr == exp_ptr)
    else $error("pointer not advanced by size");
  a_ptr_only_reads: assert property ($changed(dump_ptr) |-> $past(mem_req))
    else $error("pointer moved without access");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request changed early");
  a_reg_hold: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_cmd))
    else $error("register request changed early");
  a_mem_release: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  a_one_access: assert property (!(mem_req && reg_req))
    else $error("two accesses at once");
  a_no_rsvd_size: assert property (mem_req |-> mem_cmd.size != 2'h3)
    else $error("reserved size reached memory");
  a_refuse_quiet: assert property ($rose(cmd_error) |-> !mem_req && !reg_req)
    else $error("refused word started an access");
  c_read: cover property (rd_done);
  c_reg: cover property (reg_req && reg_ack);
  c_refuse: cover property ($rose(cmd_error));
endmodule
bind bdsc_core bdsc_monitor mon (.clk(clk), .reset_n(reset_n),
  .debug_serial_clock(debug_serial_clock),
  .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .reg_req(reg_req), .reg_cmd(reg_cmd),
  .reg_ack(reg_ack), .dump_ptr(dump_ptr), .cmd_error(cmd_error));

// ==== bdsc_host.sv ====
// debug host model: gated serial clock and framed word transfers
`timescale 1ns/1ns
module bdsc_host (
  // serial link
  output logic debug_serial_clock,
  input wire logic dbg_data_out,
  output logic dbg_data_in
);
  // clock parked high outside frames
  initial
  begin
    debug_serial_clock = 1'b1;
    dbg_data_in = 1'b0;
  end
  // one low pulse per bit, 48 ns period, device bit taken before the rise
  task automatic bit_xfer(input logic b, output logic r);
    debug_serial_clock = 1'b0;
    dbg_data_in = b;
    #24;
    r = dbg_data_out;
    debug_serial_clock = 1'b1;
    #24;
  endtask
  // status bit then sixteen-pulse word, msb first
  task automatic xfer(input logic [15:0] w, output logic st, output logic [15:0] r);
    logic b;
    bit_xfer(1'b0, st);
    for (int i = 15; i >= 0; i--)
    begin
      bit_xfer(w[i], b);
      r[i] = b;
    end
    dbg_data_in = ~w[0]; // released line shows no stale level
    #200;
  endtask
endmodule

// ==== bdsc_pkg.sv ====
// shared constants, types and helpers for the serial debug command port
package bdsc_pkg;
  // serial frame: status bit then sixteen data bits, msb first
  localparam logic [4:0] LAST_BIT = 5'h10;
  localparam logic [15:0] NOT_READY_WORD = 16'h0000;
  localparam logic STATUS_VALID = 1'h0;
  localparam logic STATUS_NOT_READY = 1'h1;

  // operation codes (six-bit field)
  localparam logic [5:0] OP_PADDING = 6'h00;
  localparam logic [5:0] OP_MEM = 6'h06;
  localparam logic [5:0] OP_DUMP = 6'h07;
  localparam logic [5:0] OP_REG = 6'h08;

  // operand size encodings
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;

  // extension word counts
  localparam logic [2:0] EXT_ADDR_WORDS = 3'h2;
  localparam logic [2:0] EXT_LONG_WORDS = 3'h2;
  localparam logic [2:0] EXT_SHORT_WORDS = 3'h1;

  // command word layout
  typedef struct packed {
    logic [5:0] op;
    logic zero9;
    logic rd;
    logic [1:0] size;
    logic [1:0] zero54;
    logic addr_reg;
    logic [2:0] reg_num;
  } bdsc_cmd_t;

  // memory access request toward the core
  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bdsc_mem_req_t;

  // register access request toward the core
  typedef struct packed {
    logic we;
    logic addr_reg;
    logic [2:0] num;
    logic [31:0] wdata;
  } bdsc_reg_req_t;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_EXT = 2'b01,
    ST_MEM = 2'b10,
    ST_REG = 2'b11
  } bdsc_state_t;

  // operand size in bytes, zero for the reserved code
  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_bytes = 32'h0000_0001;
      SZ_WORD: size_bytes = 32'h0000_0002;
      SZ_LONG: size_bytes = 32'h0000_0004;
      default: size_bytes = 32'h0000_0000;
    endcase
  endfunction
endpackage
